// ===== core/msd_decoder.v
// move and stack opcode decoder, registered outputs
`timescale 1ns/1ps
`include "msd_defs.vh"
module msd_decoder
(
   input wire core_clk,
   input wire rstn,
   input wire insn_valid,
   input wire [31:0] insn_word,
   input wire insn_is_32,
   output reg dec_valid_q,
   output reg dec_claim_q,
   output reg dec_not_ours_q,
   output reg [3:0] dec_op_q,
   output reg [2:0] dest_reg_q,
   output reg [2:0] src_reg_q,
   output reg [2:0] reg_group_q,
   output reg accumulator_zero_q,
   output reg accumulator_one_q,
   output reg data_register_low_half_q,
   output reg data_register_high_half_q,
   output reg scale_two_round_option_q,
   output reg signed_integer_option_q,
   output reg sign_extend_q,
   output reg stack_pointer_dec_q,
   output reg stack_pointer_inc_q,
   output reg [7:0] dreg_range_mask_q,
   output reg [7:0] preg_range_mask_q,
   output reg preg_lim_bad_q,
   output reg [17:0] frame_size_immediate_q
);

   //==============================================================
   // helpers
   function in_rng16;
      input [15:0] v;
      input [15:0] lo;
      input [15:0] hi;
      begin
         in_rng16 = (v >= lo) && (v <= hi);
      end
   endfunction

   // half moves: low word is fixed pattern with dreg in bits 8:6
   function half_ok;
      input [15:0] v;
      input [15:0] lo;
      input [15:0] hi;
      begin
         half_ok = in_rng16(v, lo, hi) && (v[5:0] == 6'h00);
      end
   endfunction

   // mask of registers from lim up to top
   function [7:0] range_mask;
      input [2:0] lim;
      input [2:0] top;
      integer i;
      begin
         range_mask = 8'h00;
         for (i = 0; i < 8; i = i + 1)
            if ((i >= lim) && (i <= top))
               range_mask[i] = 1'b1;
      end
   endfunction

   //==============================================================
   // decode
   wire [15:0] lo16 = insn_word[15:0];
   wire [15:0] hi16 = insn_word[31:16];
   reg [3:0] op_d;
   reg [2:0] dest_d;
   reg [2:0] src_d;
   reg [2:0] grp_d;
   reg [7:0] dmask_d;
   reg [7:0] pmask_d;
   reg pbad_d;
   reg [17:0] frame_d;

   always @*
   begin
      op_d = `MSD_OP_NONE;
      dest_d = 3'h0;
      src_d = 3'h0;
      grp_d = 3'h0;
      dmask_d = 8'h00;
      pmask_d = 8'h00;
      pbad_d = 1'b0;
      frame_d = 18'h0_0000;
      if (insn_is_32)
      begin
         if ((hi16 == `MSD_ACC0_LOW_UPPER)
             && half_ok(lo16, `MSD_LO_HALF_LO, `MSD_LO_HALF_HI))
         begin
            op_d = `MSD_OP_ACC0_LOW;
            dest_d = lo16[8:6];
         end
         else if ((hi16 == `MSD_ACC1_HIGH_UPPER)
                  && half_ok(lo16, `MSD_HI_HALF_LO, `MSD_HI_HALF_HI))
         begin
            op_d = `MSD_OP_ACC1_HIGH;
            dest_d = lo16[8:6];
         end
         else if ((hi16 == `MSD_ACC_BOTH_UPPER)
                  && half_ok(lo16, `MSD_LO_HALF_LO, `MSD_LO_HALF_HI))
         begin
            op_d = `MSD_OP_ACC_BOTH;
            dest_d = lo16[8:6];
         end
         else if (hi16 == `MSD_LINK_HI16)
         begin
            op_d = `MSD_OP_LINK;
            frame_d = {lo16, 2'b00};
         end
      end
      else if (in_rng16(lo16, `MSD_BZX_LO, `MSD_BZX_HI))
      begin
         op_d = `MSD_OP_BYTE_ZX;
         src_d = lo16[5:3];
         dest_d = lo16[2:0];
      end
      else if (in_rng16(lo16, `MSD_BSX_LO, `MSD_BSX_HI))
      begin
         op_d = `MSD_OP_BYTE_SX;
         src_d = lo16[5:3];
         dest_d = lo16[2:0];
      end
      else if (in_rng16(lo16, `MSD_PUSH_LO, `MSD_PUSH_HI))
      begin
         op_d = `MSD_OP_PUSH;
         grp_d = lo16[5:3];
         src_d = lo16[2:0];
      end
      else if (in_rng16(lo16, `MSD_POP_LO, `MSD_POP_HI))
      begin
         op_d = `MSD_OP_POP;
         grp_d = lo16[5:3];
         dest_d = lo16[2:0];
      end
      else if (in_rng16(lo16, `MSD_POPM_D_LO, `MSD_POPM_D_HI))
      begin
         op_d = `MSD_OP_POP_MULTI;
         dmask_d = range_mask(lo16[5:3], `MSD_DREG_TOP);
         pmask_d = range_mask(lo16[2:0], `MSD_PREG_TOP);
         pbad_d = lo16[2:0] > `MSD_PREG_MAXLIM;
      end
      else if (in_rng16(lo16, `MSD_POPM_DP_LO, `MSD_POPM_DP_HI))
      begin
         op_d = `MSD_OP_POP_MULTI;
         dmask_d = range_mask(lo16[5:3], `MSD_DREG_TOP);
      end
      else if (in_rng16(lo16, `MSD_POPM_P_LO, `MSD_POPM_P_HI))
      begin
         op_d = `MSD_OP_POP_MULTI;
         pmask_d = range_mask(lo16[2:0], `MSD_PREG_TOP);
         pbad_d = lo16[2:0] > `MSD_PREG_MAXLIM;
      end
   end

   //==============================================================
   // per-operation control flags, gated by insn_valid
   reg claim_d;
   reg not_ours_d;
   reg acc_zero_d;
   reg acc_one_d;
   reg low_half_d;
   reg high_half_d;
   reg scale_round_d;
   reg signed_int_d;
   reg sign_ext_d;
   reg stk_dec_d;
   reg stk_inc_d;
   reg lim_bad_d;
   reg [3:0] op_out_d;

   always @*
   begin
      claim_d = 1'b0;
      not_ours_d = 1'b0;
      acc_zero_d = 1'b0;
      acc_one_d = 1'b0;
      low_half_d = 1'b0;
      high_half_d = 1'b0;
      scale_round_d = 1'b0;
      signed_int_d = 1'b0;
      sign_ext_d = 1'b0;
      stk_dec_d = 1'b0;
      stk_inc_d = 1'b0;
      lim_bad_d = 1'b0;
      op_out_d = `MSD_OP_NONE;
      if (insn_valid)
      begin
         op_out_d = op_d;
         lim_bad_d = pbad_d;
         case (op_d)
            `MSD_OP_BYTE_ZX:
            begin
               claim_d = 1'b1;
            end
            `MSD_OP_BYTE_SX:
            begin
               claim_d = 1'b1;
               sign_ext_d = 1'b1;
            end
            `MSD_OP_ACC0_LOW:
            begin
               claim_d = 1'b1;
               acc_zero_d = 1'b1;
               low_half_d = 1'b1;
               scale_round_d = 1'b1;
            end
            `MSD_OP_ACC1_HIGH:
            begin
               claim_d = 1'b1;
               acc_one_d = 1'b1;
               high_half_d = 1'b1;
               scale_round_d = 1'b1;
            end
            `MSD_OP_ACC_BOTH:
            begin
               claim_d = 1'b1;
               acc_zero_d = 1'b1;
               acc_one_d = 1'b1;
               low_half_d = 1'b1;
               high_half_d = 1'b1;
               signed_int_d = 1'b1;
            end
            `MSD_OP_PUSH:
            begin
               claim_d = 1'b1;
               stk_dec_d = 1'b1;
            end
            `MSD_OP_POP:
            begin
               claim_d = 1'b1;
               stk_inc_d = 1'b1;
            end
            `MSD_OP_POP_MULTI:
            begin
               claim_d = 1'b1;
               stk_inc_d = 1'b1;
            end
            `MSD_OP_LINK:
            begin
               claim_d = 1'b1;
               stk_dec_d = 1'b1;
            end
            default:
            begin
               not_ours_d = 1'b1;
            end
         endcase
      end
   end

   //==============================================================
   // output registers
   always @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         dec_valid_q <= 1'b0;
         dec_claim_q <= 1'b0;
         dec_not_ours_q <= 1'b0;
         dec_op_q <= `MSD_OP_NONE;
         dest_reg_q <= 3'h0;
         src_reg_q <= 3'h0;
         reg_group_q <= 3'h0;
         accumulator_zero_q <= 1'b0;
         accumulator_one_q <= 1'b0;
         data_register_low_half_q <= 1'b0;
         data_register_high_half_q <= 1'b0;
         scale_two_round_option_q <= 1'b0;
         signed_integer_option_q <= 1'b0;
         sign_extend_q <= 1'b0;
         stack_pointer_dec_q <= 1'b0;
         stack_pointer_inc_q <= 1'b0;
         dreg_range_mask_q <= 8'h00;
         preg_range_mask_q <= 8'h00;
         preg_lim_bad_q <= 1'b0;
         frame_size_immediate_q <= 18'h0_0000;
      end
      else
      begin
         dec_valid_q <= insn_valid;
         dec_claim_q <= claim_d;
         dec_not_ours_q <= not_ours_d;
         dec_op_q <= op_out_d;
         dest_reg_q <= dest_d;
         src_reg_q <= src_d;
         reg_group_q <= grp_d;
         accumulator_zero_q <= acc_zero_d;
         accumulator_one_q <= acc_one_d;
         data_register_low_half_q <= low_half_d;
         data_register_high_half_q <= high_half_d;
         scale_two_round_option_q <= scale_round_d;
         signed_integer_option_q <= signed_int_d;
         sign_extend_q <= sign_ext_d;
         stack_pointer_dec_q <= stk_dec_d;
         stack_pointer_inc_q <= stk_inc_d;
         dreg_range_mask_q <= dmask_d;
         preg_range_mask_q <= pmask_d;
         preg_lim_bad_q <= lim_bad_d;
         frame_size_immediate_q <= frame_d;
      end
   end

endmodule // msd_decoder

// ===== core/msd_defs.vh
// opcode constants for the move and stack opcode decoder
//==============================================================
// Overview of operation
// - 0x4340-0x437F: byte move, zero extended
// - 0x4300-0x433F: byte move, sign extended
// - 0xC0233800-39C0: acc0 to low half, scale-round
// - 0xC0271800-19C0: acc1 to high half, scale-round
// - 0xC1073800-39C0: both accumulators, signed integer
// - 0x0140-0x017F: single push, pre-decrement stack
// - 0x0100-0x013F: single pop, post-increment stack
// - data pop field is lowest of range to seven
// - pointer pop field lowest to five, max four; the code also decodes five and sets preg_lim_bad_q for it
// - 0xE800xxxx: linkage, frame size field times four
//==============================================================
`ifndef MSD_DEFS_VH
`define MSD_DEFS_VH
`define MSD_BZX_LO 16'h4340
`define MSD_BZX_HI 16'h437F
`define MSD_BSX_LO 16'h4300
`define MSD_BSX_HI 16'h433F
`define MSD_PUSH_LO 16'h0140
`define MSD_PUSH_HI 16'h017F
`define MSD_POP_LO 16'h0100
`define MSD_POP_HI 16'h013F
`define MSD_POPM_D_LO 16'h0580
`define MSD_POPM_D_HI 16'h05BD
`define MSD_POPM_DP_LO 16'h0500
`define MSD_POPM_DP_HI 16'h0538
`define MSD_POPM_P_LO 16'h0480
`define MSD_POPM_P_HI 16'h0485
`define MSD_ACC0_LOW_UPPER 16'hC023
`define MSD_ACC1_HIGH_UPPER 16'hC027
`define MSD_ACC_BOTH_UPPER 16'hC107
`define MSD_LO_HALF_LO 16'h3800
`define MSD_LO_HALF_HI 16'h39C0
`define MSD_HI_HALF_LO 16'h1800
`define MSD_HI_HALF_HI 16'h19C0
`define MSD_LINK_HI16 16'hE800
`define MSD_PREG_TOP 3'h5
`define MSD_PREG_MAXLIM 3'h4
`define MSD_DREG_TOP 3'h7
`define MSD_OP_NONE 4'h0
`define MSD_OP_BYTE_ZX 4'h1
`define MSD_OP_BYTE_SX 4'h2
`define MSD_OP_ACC0_LOW 4'h3
`define MSD_OP_ACC1_HIGH 4'h4
`define MSD_OP_ACC_BOTH 4'h5
`define MSD_OP_PUSH 4'h6
`define MSD_OP_POP 4'h7
`define MSD_OP_POP_MULTI 4'h8
`define MSD_OP_LINK 4'h9
`endif

// ===== verif/msd_decoder_props.sv
// concurrent checks on the decoder ports
`timescale 1ns/1ps
module msd_decoder_props
(
   input wire core_clk,
   input wire rstn,
   input wire insn_valid,
   input wire [31:0] insn_word,
   input wire insn_is_32,
   input wire dec_valid_q,
   input wire dec_claim_q,
   input wire dec_not_ours_q,
   input wire [3:0] dec_op_q,
   input wire [2:0] dest_reg_q,
   input wire sign_extend_q,
   input wire stack_pointer_dec_q,
   input wire stack_pointer_inc_q,
   input wire [7:0] dreg_range_mask_q,
   input wire [17:0] frame_size_immediate_q
);
   //==============================
   // properties
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!rstn);
   wire m16 = insn_valid && !insn_is_32;
   property p_resp;
      insn_valid |=> dec_valid_q && (dec_claim_q ^ dec_not_ours_q);
   endproperty
   a_resp: assert property (p_resp) else $error("no single answer");
   property p_zx;
      m16 && insn_word[15:6] == 10'h10d |=> dec_op_q == 4'h1 && !sign_extend_q;
   endproperty
   a_zx: assert property (p_zx) else $error("zero byte move wrong");
   property p_sx;
      m16 && insn_word[15:6] == 10'h10c |=> dec_op_q == 4'h2 && sign_extend_q;
   endproperty
   a_sx: assert property (p_sx) else $error("sign byte move wrong");
   property p_push;
      m16 && insn_word[15:6] == 10'h005 |=> dec_op_q == 4'h6 && stack_pointer_dec_q;
   endproperty
   a_push: assert property (p_push) else $error("push wrong");
   property p_pop;
      m16 && insn_word[15:6] == 10'h004 |=> dec_op_q == 4'h7 && stack_pointer_inc_q
         && dest_reg_q == $past(insn_word[2:0]);
   endproperty
   a_pop: assert property (p_pop) else $error("pop wrong");
   property p_dmask;
      m16 && insn_word[15:0] == 16'h0520 |=> dreg_range_mask_q == 8'hf0;
   endproperty
   a_dmask: assert property (p_dmask) else $error("data range wrong");
   property p_link;
      insn_valid && insn_is_32 && insn_word[31:16] == 16'he800 |=> dec_op_q == 4'h9
         && frame_size_immediate_q == {$past(insn_word[15:0]), 2'b00};
   endproperty
   a_link: assert property (p_link) else $error("linkage wrong");
   property p_none;
      dec_not_ours_q |-> dec_op_q == 4'h0;
   endproperty
   a_none: assert property (p_none) else $error("foreign op code");
endmodule // msd_decoder_props
bind msd_decoder msd_decoder_props i_props (.core_clk, .rstn, .insn_valid, .insn_word,
   .insn_is_32, .dec_valid_q, .dec_claim_q, .dec_not_ours_q, .dec_op_q, .dest_reg_q,
   .sign_extend_q, .stack_pointer_dec_q, .stack_pointer_inc_q, .dreg_range_mask_q,
   .frame_size_immediate_q);

// ===== verif/msd_fetch_model.sv
// fetch stage model presenting opcodes
`timescale 1ns/1ps
module msd_fetch_model
(
   output reg insn_valid,
   output reg [31:0] insn_word,
   output reg insn_is_32
);
   //==============================
   // drive
   initial
   begin
      insn_valid = 1'b0;
      insn_word = 32'h0000_0000;
      insn_is_32 = 1'b0;
   end
   task send(input [31:0] w, input s);
   begin
      insn_valid = 1'b1;
      insn_word = w;
      insn_is_32 = s;
   end
   endtask
   // released word shows inverse, not stale value
   task idle;
   begin
      insn_valid = 1'b0;
      insn_word = ~insn_word;
   end
   endtask
endmodule // msd_fetch_model

// ===== verif/test_move_stack_opcode_decoder.sv
// self-checking bench for the move and stack opcode decoder
`timescale 1ns/1ps
`include "msd_defs.vh"
module test_move_stack_opcode_decoder;
   //==============================
   // harness
   reg core_clk;
   reg rstn;
   integer n_errors;
   integer n_compared;
   wire insn_valid, insn_is_32, dec_valid_q, dec_claim_q, dec_not_ours_q, sign_extend_q;
   wire [31:0] insn_word;
   wire [3:0] dec_op_q;
   wire [2:0] dest_reg_q, src_reg_q, reg_group_q;
   wire accumulator_zero_q, accumulator_one_q, data_register_low_half_q;
   wire data_register_high_half_q, scale_two_round_option_q, signed_integer_option_q;
   wire stack_pointer_dec_q, stack_pointer_inc_q, preg_lim_bad_q;
   wire [7:0] dreg_range_mask_q, preg_range_mask_q;
   wire [17:0] frame_size_immediate_q;
   msd_fetch_model i_msd_fetch_model (.insn_valid, .insn_word, .insn_is_32);
   msd_decoder i_msd_decoder (.core_clk, .rstn, .insn_valid, .insn_word, .insn_is_32,
      .dec_valid_q, .dec_claim_q, .dec_not_ours_q, .dec_op_q, .dest_reg_q, .src_reg_q,
      .reg_group_q, .accumulator_zero_q, .accumulator_one_q, .data_register_low_half_q,
      .data_register_high_half_q, .scale_two_round_option_q, .signed_integer_option_q,
      .sign_extend_q, .stack_pointer_dec_q, .stack_pointer_inc_q, .dreg_range_mask_q,
      .preg_range_mask_q, .preg_lim_bad_q, .frame_size_immediate_q);
   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   task chk(input string n, input [17:0] s, input [17:0] e);
   begin
      n_compared = n_compared + 1;
      if (s !== e)
      begin
         n_errors = n_errors + 1;
         $display("ERROR %s exp %h seen %h", n, e, s);
      end
   end
   endtask
   task go(input [31:0] w, input s, input [3:0] op);
   begin
      i_msd_fetch_model.send(w, s);
      @(posedge core_clk);
      #1;
      chk("op", {dec_valid_q, dec_op_q}, {1'b1, op});
   end
   endtask
   task done(input string n);
   begin
      i_msd_fetch_model.idle;
      @(posedge core_clk);
      #1;
      chk("idle", dec_valid_q, 1'b0);
      $display("done %s", n);
   end
   endtask
   //==============================
   // scenarios, back to back
   task t_byte;
   begin
      go(32'h0000_4345, 1'b0, `MSD_OP_BYTE_ZX);
      chk("dst", {src_reg_q, dest_reg_q}, 6'h05);
      go(32'h0000_437f, 1'b0, `MSD_OP_BYTE_ZX);
      go(32'h0000_4300, 1'b0, `MSD_OP_BYTE_SX);
      go(32'h0000_433f, 1'b0, `MSD_OP_BYTE_SX);
      chk("sx", {sign_extend_q, src_reg_q, dest_reg_q}, 7'h7f);
      done("byte");
   end
   endtask
   task t_half;
   begin
      go(32'hc023_39c0, 1'b1, `MSD_OP_ACC0_LOW);
      chk("lo", {accumulator_zero_q, data_register_low_half_q, scale_two_round_option_q,
         dest_reg_q}, 6'h3f);
      go(32'hc027_1800, 1'b1, `MSD_OP_ACC1_HIGH);
      chk("hi", {accumulator_one_q, data_register_high_half_q, scale_two_round_option_q,
         dest_reg_q}, 6'h38);
      go(32'hc107_3840, 1'b1, `MSD_OP_ACC_BOTH);
      chk("is", {accumulator_zero_q, accumulator_one_q, data_register_low_half_q,
         data_register_high_half_q, signed_integer_option_q, dest_reg_q}, 8'hf9);
      done("half");
   end
   endtask
   task t_stack;
   begin
      go(32'h0000_017f, 1'b0, `MSD_OP_PUSH);
      chk("push", {stack_pointer_dec_q, reg_group_q, src_reg_q}, 7'h7f);
      go(32'h0000_0100, 1'b0, `MSD_OP_POP);
      chk("pop", {stack_pointer_inc_q, stack_pointer_dec_q}, 2'h2);
      go(32'h0000_0520, 1'b0, `MSD_OP_POP_MULTI);
      chk("dmask", dreg_range_mask_q, 8'hf0);
      go(32'h0000_0482, 1'b0, `MSD_OP_POP_MULTI);
      chk("pmask", {preg_lim_bad_q, preg_range_mask_q}, 9'h03c);
      go(32'h0000_0485, 1'b0, `MSD_OP_POP_MULTI);
      chk("pbad", preg_lim_bad_q, 1'b1);
      done("stack");
   end
   endtask
   task t_link;
   begin
      go(32'he800_0010, 1'b1, `MSD_OP_LINK);
      chk("frame", frame_size_immediate_q, 18'h0_0040);
      go(32'he800_ffff, 1'b1, `MSD_OP_LINK);
      chk("fmax", frame_size_immediate_q, 18'h3_fffc);
      go(32'hc023_3801, 1'b1, `MSD_OP_NONE);
      go(32'he801_0000, 1'b1, `MSD_OP_NONE);
      go(32'h0000_0140, 1'b1, `MSD_OP_NONE);
      go(32'h0000_4380, 1'b0, `MSD_OP_NONE);
      chk("foreign", {dec_not_ours_q, dec_claim_q}, 2'h2);
      done("link");
   end
   endtask
   task final_report;
   begin
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   end
   endtask
   initial
   begin
      n_errors = 0;
      n_compared = 0;
      rstn = 1'b0;
      repeat (10) @(posedge core_clk);
      #1;
      chk("rst", dec_valid_q, 1'b0);
      rstn = 1'b1;
      t_byte;
      t_half;
      t_stack;
      t_link;
      final_report;
   end
   initial
   begin
      #50000;
      n_errors = n_errors + 1;
      final_report;
   end
endmodule // test_move_stack_opcode_decoder
